/* hdl/awr_pkg.sv */
// constants and types for the serial word receiver
package awr_pkg;
  localparam int CLK_NS      = 20;
  localparam int TCLK_NS     = 1000;
  localparam int SAMPLE_DIV  = TCLK_NS / CLK_NS;
  localparam int LS_DIV      = 8;
  localparam int DIV_W       = 8;
  localparam int SR_W        = 10;
  localparam int HALF_W      = 5;
  localparam int RUN_LEN     = 3;
  localparam int BIT_MIN     = 8;
  localparam int BIT_MAX     = 12;
  localparam int GAP_SAMPLES = 10;
  localparam int GAP_COUNT   = 3;
  localparam int WORD_BITS   = 32;
  localparam int FIFO_DEPTH  = 32;
  localparam int HALF_LEVEL  = 16;
  localparam int LABEL_W     = 8;
  localparam int LUT_WORDS   = 8;
  localparam int ADDR_W      = 8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_LUT0 = 8'h10;
  localparam logic [7:0] OFS_FILL = 8'h30;

  localparam int CB_RATE   = 0;
  localparam int CB_LFE    = 2;
  localparam int CB_PCE    = 4;
  localparam int CB_RXEN   = 5;
  localparam int CB_SDM    = 6;
  localparam int CB_B10    = 7;
  localparam int CB_B9     = 8;
  localparam int CB_ORDER  = 11;
  localparam int CB_FLAGS  = 15;
  localparam int CTRL_W    = 16;
  localparam logic [15:0] CTRL_RST = 16'h0020;

  localparam int SB_EMPTY = 0;
  localparam int SB_HALF  = 1;
  localparam int SB_FULL  = 2;

  typedef enum logic [2:0] {
    ST_GAP  = 3'b001,
    ST_IDLE = 3'b010,
    ST_RECV = 3'b100
  } awr_state_t;
endpackage : awr_pkg

/* hdl/awr_top.sv */
// serial avionics word receiver with label filter, fifo and apb registers
//
// Summary of operation
// [RULE_01] order select 0 reverses host bits 1-8; 1 maps straight; rest straight.
// [RULE_02] input outside all three bands shifts no high sample, so rejects the word.
// [RULE_03] three 10-bit sample registers; at most one takes a high each sample.
// [RULE_04] data bit needs three one/zero in upper half, three nulls in lower half.
// [RULE_05] word gap null needs three nulls in both halves of null register.
// [RULE_06] each bit must start 8 to 12 samples after the previous one.
// [RULE_07] gap timer checks nulls every 10 samples; three nulls re-arm reception.
// [RULE_08] far side supplies an accurate timing clock, under 0.1% error.
// [RULE_09] with parity check on, odd one count gives zero in bit 32.
// [RULE_10] thirty-two valid bits raise the end of word strobe.
// [RULE_11] store only if label and bit 10/9 checks pass or are disabled.
// [RULE_12] receive fifo holds 32 words of 32 bits.
// [RULE_13] stored word sets data ready and clears empty until fifo drains.
// [RULE_14] host reads one word per data read; repeated reads drain the fifo.
// [RULE_15] full flag at 32 words; new words then overwrite the last location.
// [RULE_16] half full flag high with 16 or more words held.
// [RULE_17] 256-entry label table; 1 keeps the label, 0 discards it.
// [RULE_18] host writes the label table by word writes or fill.
// [RULE_19] host loads the label table before enabling label filtering.
// [RULE_20] discarded word leaves no fifo write, flag change or data ready.
// [RULE_21] host reads back the label table.
// [RULE_22] rate select 0 samples at timing clock, 1 at one eighth of it.
// [RULE_23] flag pin shows empty with select 0, full with select 1.
// [RULE_24] master clear aborts reception, clears fifo, flags, pin; keeps control.
// [RULE_25] receiver enable 0 ignores all bus traffic.
// [RULE_26] bad bit or timing abandons word and waits for a full word gap.
// [RULE_27] words leave the fifo oldest first.
`timescale 1ns/1ps
module awr_top #(
  parameter int SAMPLE_DIV = awr_pkg::SAMPLE_DIV,
  parameter int DEPTH      = awr_pkg::FIFO_DEPTH,
  parameter int AW         = $clog2(DEPTH)
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [awr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        line_one,
  input  wire logic                        line_zero,
  input  wire logic                        line_null,
  input  wire logic                        master_clear,
  output logic                             fifo_flag_pin,
  output logic                             data_ready
);

  localparam int CW = AW + 1;

  function automatic logic run3(input logic [awr_pkg::HALF_W-1:0] x);
    logic r;
    r = 1'b0;
    for (int i = 0; i <= awr_pkg::HALF_W - awr_pkg::RUN_LEN; i++) begin
      r = r | (&x[i +: awr_pkg::RUN_LEN]);
    end
    return r;
  endfunction : run3

  function automatic logic [2:0] lut_word(input logic [awr_pkg::ADDR_W-1:0] a);
    logic [awr_pkg::ADDR_W-1:0] o;
    o = a - awr_pkg::OFS_LUT0;
    return o[4:2];
  endfunction : lut_word

  logic [awr_pkg::CTRL_W-1:0]    ctrl_q;
  logic [255:0]                  lut_q;
  logic [awr_pkg::DIV_W-1:0]     div_q;
  logic [2:0]                    ls_q;
  logic                          tick_q;
  logic [awr_pkg::SR_W-1:0]      one_sr_q;
  logic [awr_pkg::SR_W-1:0]      zero_sr_q;
  logic [awr_pkg::SR_W-1:0]      null_sr_q;
  logic                          bit_prev_q;
  awr_pkg::awr_state_t           state_q;
  logic [5:0]                    bcnt_q;
  logic [3:0]                    ivl_q;
  logic [3:0]                    gtmr_q;
  logic [1:0]                    gcnt_q;
  logic [31:0]                   sh_q;
  logic                          eow_q;
  logic [31:0]                   mem [DEPTH];
  logic [AW-1:0]                 wptr_q;
  logic [AW-1:0]                 rptr_q;
  logic [CW-1:0]                 cnt_q;
  logic [CW-1:0]                 cnt_d;
  logic                          empty_q;
  logic                          half_q;
  logic                          full_q;
  logic                          pready_q;
  logic                          pslverr_q;
  logic [31:0]                   prdata_q;
  logic                          flag_q;
  logic                          dr_q;

  logic                          rx_en;
  logic                          bit_one;
  logic                          bit_zero;
  logic                          bit_ev;
  logic                          gap_null;
  logic [31:0]                   hw;
  logic                          label_ok;
  logic                          sd_ok;
  logic                          wr_en;
  logic                          wr_norm;
  logic                          wr_over;
  logic                          acc;
  logic                          done;
  logic                          pop;
  logic                          hit;
  logic [31:0]                   rdata;
  logic                          in_one;
  logic                          in_zero;
  logic                          in_null;

  assign rx_en = ctrl_q[awr_pkg::CB_RXEN];

  // sample timing from the bus clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      ls_q   <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (div_q == awr_pkg::DIV_W'(SAMPLE_DIV - 1)) begin // [RULE_08]
        div_q <= '0;
        if (!ctrl_q[awr_pkg::CB_RATE] || ls_q == 3'(awr_pkg::LS_DIV - 1)) begin // [RULE_22]
          ls_q   <= '0;
          tick_q <= 1'b1;
        end else begin
          ls_q <= ls_q + 3'h1;
        end
      end else begin
        div_q <= div_q + awr_pkg::DIV_W'(1);
      end
    end
  end

  // one band at a time; between bands nothing is high
  always_comb begin
    in_one  = line_one & rx_en; // [RULE_25]
    in_zero = line_zero & ~line_one & rx_en; // [RULE_03]
    in_null = line_null & ~line_one & ~line_zero & rx_en; // [RULE_02]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_sr_q   <= '0;
      zero_sr_q  <= '0;
      null_sr_q  <= '0;
      bit_prev_q <= 1'b0;
    end else if (master_clear) begin
      one_sr_q   <= '0;
      zero_sr_q  <= '0;
      null_sr_q  <= '0;
      bit_prev_q <= 1'b0;
    end else if (tick_q) begin
      one_sr_q   <= {one_sr_q[awr_pkg::SR_W-2:0], in_one}; // [RULE_03]
      zero_sr_q  <= {zero_sr_q[awr_pkg::SR_W-2:0], in_zero};
      null_sr_q  <= {null_sr_q[awr_pkg::SR_W-2:0], in_null};
      bit_prev_q <= bit_one | bit_zero;
    end
  end

  // upper half holds older samples, lower half the newest
  always_comb begin
    bit_one  = run3(one_sr_q[9:5]) & run3(null_sr_q[4:0]); // [RULE_04]
    bit_zero = run3(zero_sr_q[9:5]) & run3(null_sr_q[4:0]);
    bit_ev   = tick_q & (bit_one | bit_zero) & ~bit_prev_q;
    gap_null = run3(null_sr_q[9:5]) & run3(null_sr_q[4:0]); // [RULE_05]
  end

  // word assembly, bit spacing and gap check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= awr_pkg::ST_GAP;
      bcnt_q  <= '0;
      ivl_q   <= '0;
      gtmr_q  <= '0;
      gcnt_q  <= '0;
      sh_q    <= '0;
      eow_q   <= 1'b0;
    end else if (master_clear || !rx_en) begin // [RULE_24]
      state_q <= awr_pkg::ST_GAP;
      bcnt_q  <= '0;
      ivl_q   <= '0;
      gtmr_q  <= '0;
      gcnt_q  <= '0;
      eow_q   <= 1'b0;
    end else begin
      eow_q <= 1'b0;
      if (tick_q) begin
        case (state_q)
          awr_pkg::ST_GAP: begin
            if (gtmr_q == 4'(awr_pkg::GAP_SAMPLES - 1)) begin // [RULE_07]
              gtmr_q <= '0;
              if (!gap_null) begin
                gcnt_q <= '0;
              end else if (gcnt_q == 2'(awr_pkg::GAP_COUNT - 1)) begin
                gcnt_q  <= '0;
                state_q <= awr_pkg::ST_IDLE;
              end else begin
                gcnt_q <= gcnt_q + 2'h1;
              end
            end else begin
              gtmr_q <= gtmr_q + 4'h1;
            end
          end
          awr_pkg::ST_IDLE: begin
            if (bit_ev) begin
              sh_q    <= {31'h0, bit_one};
              bcnt_q  <= 6'h01;
              ivl_q   <= '0;
              state_q <= awr_pkg::ST_RECV;
            end
          end
          awr_pkg::ST_RECV: begin
            if (ivl_q != 4'hF) begin
              ivl_q <= ivl_q + 4'h1;
            end
            if (bit_ev) begin
              ivl_q <= '0;
              if (ivl_q < 4'(awr_pkg::BIT_MIN - 1) ||
                  ivl_q > 4'(awr_pkg::BIT_MAX - 1)) begin // [RULE_06]
                gtmr_q  <= '0;
                gcnt_q  <= '0;
                state_q <= awr_pkg::ST_GAP; // [RULE_26]
              end else begin
                sh_q[bcnt_q[4:0]] <= bit_one;
                bcnt_q            <= bcnt_q + 6'h01;
                if (bcnt_q == 6'(awr_pkg::WORD_BITS - 1)) begin
                  eow_q   <= 1'b1; // [RULE_10]
                  gtmr_q  <= '0;
                  gcnt_q  <= '0;
                  state_q <= awr_pkg::ST_GAP; // [RULE_07]
                end
              end
            end else if (ivl_q >= 4'(awr_pkg::BIT_MAX - 1)) begin // [RULE_06]
              gtmr_q  <= '0;
              gcnt_q  <= '0;
              state_q <= awr_pkg::ST_GAP; // [RULE_26]
            end
          end
          default: begin
            state_q <= awr_pkg::ST_GAP;
          end
        endcase
      end
    end
  end

  // host word and acceptance
  always_comb begin
    hw = sh_q;
    if (!ctrl_q[awr_pkg::CB_ORDER]) begin
      for (int i = 0; i < awr_pkg::LABEL_W; i++) begin
        hw[i] = sh_q[awr_pkg::LABEL_W-1-i]; // [RULE_01]
      end
    end
    if (ctrl_q[awr_pkg::CB_PCE]) begin
      hw[31] = ~(^sh_q); // [RULE_09]
    end
    label_ok = ~ctrl_q[awr_pkg::CB_LFE] | lut_q[hw[7:0]]; // [RULE_17] [RULE_19]
    sd_ok    = ~ctrl_q[awr_pkg::CB_SDM] |
               ((sh_q[9] == ctrl_q[awr_pkg::CB_B10]) && (sh_q[8] == ctrl_q[awr_pkg::CB_B9]));
    wr_en    = eow_q & label_ok & sd_ok; // [RULE_11] [RULE_20]
    wr_norm  = wr_en & (~full_q | pop);
    wr_over  = wr_en & full_q & ~pop; // [RULE_15]
    cnt_d    = cnt_q + CW'(wr_norm) - CW'(pop);
  end

  // fifo storage
  always_ff @(posedge pclk) begin
    if (wr_norm) begin
      mem[wptr_q] <= hw; // [RULE_12]
    end else if (wr_over) begin
      mem[wptr_q - AW'(1)] <= hw; // [RULE_15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      cnt_q   <= '0;
      empty_q <= 1'b1;
      half_q  <= 1'b0;
      full_q  <= 1'b0;
      dr_q    <= 1'b0;
      flag_q  <= 1'b0;
    end else if (master_clear) begin // [RULE_24]
      wptr_q  <= '0;
      rptr_q  <= '0;
      cnt_q   <= '0;
      empty_q <= 1'b1;
      half_q  <= 1'b0;
      full_q  <= 1'b0;
      dr_q    <= 1'b0;
      flag_q  <= 1'b0;
    end else begin
      if (wr_norm) begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (pop) begin
        rptr_q <= rptr_q + AW'(1); // [RULE_27]
      end
      cnt_q   <= cnt_d;
      empty_q <= (cnt_d == '0); // [RULE_13]
      half_q  <= (cnt_d >= CW'(awr_pkg::HALF_LEVEL)); // [RULE_16]
      full_q  <= (cnt_d == CW'(DEPTH)); // [RULE_15]
      if (wr_en) begin
        dr_q <= 1'b1; // [RULE_13]
      end else if (cnt_d == '0) begin
        dr_q <= 1'b0;
      end
      if (ctrl_q[awr_pkg::CB_FLAGS]) begin
        flag_q <= (cnt_d == CW'(DEPTH)); // [RULE_23]
      end else begin
        flag_q <= (cnt_d == '0);
      end
    end
  end

  // apb decode
  assign acc  = psel & penable;
  assign done = acc & pready_q;
  assign pop  = done & ~pwrite & (paddr == awr_pkg::OFS_DATA) & ~empty_q; // [RULE_14]

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (paddr == awr_pkg::OFS_CTRL) begin
      rdata = {16'h0000, ctrl_q};
    end else if (paddr == awr_pkg::OFS_STAT) begin
      rdata = {29'h0, full_q, half_q, empty_q};
    end else if (paddr == awr_pkg::OFS_DATA) begin
      rdata = empty_q ? 32'h0000_0000 : mem[rptr_q]; // [RULE_14]
    end else if (paddr >= awr_pkg::OFS_LUT0 && paddr < awr_pkg::OFS_FILL &&
                 paddr[1:0] == 2'h0) begin
      rdata = lut_q[{lut_word(paddr), 5'h00} +: 32]; // [RULE_21]
    end else if (paddr == awr_pkg::OFS_FILL) begin
      rdata = 32'h0000_0000;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q <= acc & ~pready_q;
      if (acc && !pready_q) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rdata;
        pslverr_q <= ~hit;
      end else if (done) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // control and label table; master clear leaves these alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= awr_pkg::CTRL_RST;
      lut_q  <= '0;
    end else if (done && pwrite && hit) begin
      if (paddr == awr_pkg::OFS_CTRL) begin
        ctrl_q <= pwdata[awr_pkg::CTRL_W-1:0];
      end else if (paddr == awr_pkg::OFS_FILL) begin
        lut_q <= {256{pwdata[0]}}; // [RULE_18]
      end else if (paddr >= awr_pkg::OFS_LUT0 && paddr < awr_pkg::OFS_FILL) begin
        lut_q[{lut_word(paddr), 5'h00} +: 32] <= pwdata; // [RULE_18]
      end
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign fifo_flag_pin = flag_q;
  assign data_ready    = dr_q;

endmodule : awr_top

/* verif/awr_top_props.sv */
// assertions on the receiver bus and flag ports
`timescale 1ns/1ps
module awr_top_props #(
  parameter int SAMPLE_DIV = awr_pkg::SAMPLE_DIV,
  parameter int DEPTH      = awr_pkg::FIFO_DEPTH,
  parameter int AW         = $clog2(DEPTH)
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_one,
  input wire logic        line_zero,
  input wire logic        line_null,
  input wire logic        master_clear,
  input wire logic        fifo_flag_pin,
  input wire logic        data_ready
);
  logic sel_q;
  wire  unm = (paddr[1:0] != 2'h0) || (paddr == 8'h0C) || (paddr > awr_pkg::OFS_FILL);
  // flag pin select as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == awr_pkg::OFS_CTRL) begin
      sel_q <= pwdata[awr_pkg::CB_FLAGS];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not in second access cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready without access phase");
  a_err_decode: assert property (psel && penable && pready |-> pslverr == unm)
    else $error("error response wrong for address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_read_zero: assert property (pready && !pwrite && unm |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_held: assert property (!pready |-> $stable(prdata))
    else $error("read data moved outside a read");
  a_clear_flags: assert property (master_clear |=> !fifo_flag_pin && !data_ready)
    else $error("clear left flags set");
  a_store_pin: assert property ($rose(data_ready) && !sel_q |-> ##[0:1] !fifo_flag_pin)
    else $error("empty pin stayed high after store");
  c_store: cover property ($rose(data_ready));
  c_error: cover property (pslverr);
  c_clear: cover property (master_clear ##1 !master_clear);
endmodule : awr_top_props
bind awr_top awr_top_props #(.SAMPLE_DIV(SAMPLE_DIV), .DEPTH(DEPTH), .AW(AW))
  awr_top_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .line_one(line_one), .line_zero(line_zero), .line_null(line_null),
  .master_clear(master_clear), .fifo_flag_pin(fifo_flag_pin), .data_ready(data_ready));

/* verif/awr_top_test.sv */
// self-checking bench for the serial word receiver
`timescale 1ns/1ps
module awr_top_test;
  localparam int         DIV = 4;
  localparam logic [7:0] CT  = awr_pkg::OFS_CTRL;
  localparam logic [7:0] ST  = awr_pkg::OFS_STAT;
  localparam logic [7:0] DT  = awr_pkg::OFS_DATA;
  localparam logic [7:0] LT  = awr_pkg::OFS_LUT0;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, master_clear = 1'b0, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, fifo_flag_pin, data_ready, line_one, line_zero, line_null;
  int          bad_count = 0, compares = 0, cycles = 0;
  awr_top #(.SAMPLE_DIV(DIV)) awr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_one(line_one), .line_zero(line_zero),
    .line_null(line_null), .master_clear(master_clear), .fifo_flag_pin(fifo_flag_pin),
    .data_ready(data_ready));
  awr_tx_model awr_tx_model_inst (.pclk(pclk), .line_one(line_one), .line_zero(line_zero),
    .line_null(line_null));
  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 95000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic tx(input logic [31:0] w);
    awr_tx_model_inst.send(w, 4, 6, DIV);
  endtask : tx
  task automatic t_reset();
    rdchk(CT, 32'h0000_0020);
    rdchk(ST, 32'h0000_0001);
    chk(32'(fifo_flag_pin), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_recv();
    tx(32'h1234_56C1);
    tx(32'hA5A5_0F02);
    chk(32'(data_ready), 32'h1);
    chk(32'(fifo_flag_pin), 32'h0);
    rdchk(ST, 32'h0);
    rdchk(DT, 32'h1234_5683);
    rdchk(DT, 32'hA5A5_0F40);
    rdchk(ST, 32'h1);
    chk(32'(data_ready), 32'h0);
    rdchk(DT, 32'h0);
    wr(CT, 32'h0000_0830);
    tx(32'h8000_0003);
    tx(32'h0000_0003);
    rdchk(DT, 32'h0000_0003);
    rdchk(DT, 32'h8000_0003);
  endtask : t_recv
  task automatic t_filter();
    wr(awr_pkg::OFS_FILL, 32'h0);
    wr(LT + 8'h04, 32'h0000_0004);
    rdchk(LT + 8'h04, 32'h0000_0004);
    rdchk(LT, 32'h0);
    wr(CT, 32'h0000_0824);
    tx(32'h0000_0023);
    rdchk(ST, 32'h1);
    chk(32'(data_ready), 32'h0);
    tx(32'h0000_0022);
    wr(CT, 32'h0000_09E4);
    tx(32'h0000_0122);
    tx(32'h0000_0322);
    rdchk(DT, 32'h0000_0022);
    rdchk(DT, 32'h0000_0322);
    rdchk(ST, 32'h1);
    wr(CT, 32'h0000_0800);
    tx(32'h0000_0322);
    rdchk(ST, 32'h1);
  endtask : t_filter
  task automatic t_timing();
    wr(CT, 32'h0000_0820);
    awr_tx_model_inst.send(32'h0000_00F0, 4, 3, DIV);
    rdchk(ST, 32'h1);
    tx(32'h0000_00F0);
    rdchk(ST, 32'h0);
    master_clear <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(fifo_flag_pin), 32'h0);
    master_clear <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk(ST, 32'h1);
    rdchk(CT, 32'h0000_0820);
    chk(32'(data_ready), 32'h0);
  endtask : t_timing
  task automatic t_low();
    wr(CT, 32'h0000_0821);
    awr_tx_model_inst.send(32'h0F0F_00AA, 4, 6, DIV * 8);
    tx(32'h0000_0055);
    rdchk(DT, 32'h0F0F_00AA);
    rdchk(ST, 32'h1);
  endtask : t_low
  task automatic t_fill();
    wr(CT, 32'h0000_8820);
    for (int i = 0; i < 33; i++) begin
      tx({16'(i), 16'h0055});
      rdchk(ST, {29'h0, i >= 31, i >= 15, 1'b0});
    end
    chk(32'(fifo_flag_pin), 32'h1);
    for (int i = 0; i < 32; i++) begin
      rdchk(DT, {16'(i < 31 ? i : 32), 16'h0055});
      if (i == 0) begin
        rdchk(ST, 32'h0000_0002);
        chk(32'(fifo_flag_pin), 32'h0);
      end
      if (i == 16) begin
        rdchk(ST, 32'h0000_0000);
      end
    end
    rdchk(ST, 32'h1);
    chk(32'(fifo_flag_pin), 32'h0);
  endtask : t_fill
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_recv();
    t_filter();
    t_timing();
    t_low();
    t_fill();
    summarize();
  end
endmodule : awr_top_test

/* verif/awr_tx_model.sv */
// behavioural word transmitter driving the three band lines
`timescale 1ns/1ps
module awr_tx_model (
  input  wire logic pclk,
  output logic      line_one,
  output logic      line_zero,
  output logic      line_null
);
  initial begin
    {line_one, line_zero, line_null} = 3'b001;
  end
  // one level for n clocks, changed just after an edge
  task automatic hold(input logic [2:0] lv, input int n);
    {line_one, line_zero, line_null} <= lv;
    repeat (n) @(posedge pclk);
  endtask : hold
  // leading gap, then return-to-zero bits, bus bit 1 first
  task automatic send(input logic [31:0] w, input int hi, input int lo, input int div);
    hold(3'b001, 40 * div);
    for (int i = 0; i < 32; i++) begin
      hold(w[i] ? 3'b100 : 3'b010, hi * div);
      hold(3'b001, lo * div);
    end
  endtask : send
endmodule : awr_tx_model
